// *** ppm_defs.vh ***
// Offsets, field positions and fixed values of the power management register bank
`ifndef PPM_DEFS_VH
`define PPM_DEFS_VH

// ============================================================
// Register offsets (byte addresses in configuration space)
`define PPM_OFS_PM_CAP            8'hc0
`define PPM_OFS_IDENTITY          8'h80
`define PPM_ADDR_W                8

// ============================================================
// Identity word fields
`define PPM_PART_CODE_HI          31
`define PPM_PART_CODE_LO          16
`define PPM_MAKER_CODE_HI         15
`define PPM_MAKER_CODE_LO         0
`define PPM_CODE_W                16

// ============================================================
// Power management capability word fields
`define PPM_BIT_COLD_WAKE         31
`define PPM_BIT_HOT_OFF_WAKE      30
`define PPM_BIT_STATE2_WAKE       29
`define PPM_BIT_STATE1_WAKE       28
`define PPM_BIT_STATE0_WAKE       27
`define PPM_BIT_STATE2_SUPP       26
`define PPM_BIT_STATE1_SUPP       25
`define PPM_AUX_HI                24
`define PPM_AUX_LO                22
`define PPM_BIT_DEV_INIT          21
`define PPM_BIT_RESERVED20        20
`define PPM_BIT_WAKE_CLK          19
`define PPM_VER_HI                18
`define PPM_VER_LO                16
`define PPM_NEXT_HI               15
`define PPM_NEXT_LO               8
`define PPM_KIND_HI               7
`define PPM_KIND_LO               0

// ============================================================
// Fixed field values
`define PPM_WAKE_STATES_VAL       4'hf
`define PPM_AUX_CUR_FULL          3'h7
`define PPM_AUX_CUR_NONE          3'h0
`define PPM_SPEC_VERSION          3'h2
`define PPM_NEXT_PTR_VAL          8'h00
`define PPM_CAP_KIND_VAL          8'h01
`define PPM_ZERO_BIT              1'b0
`define PPM_ONE_BIT               1'b1

// ============================================================
// Reset values
`define PPM_RDATA_RST             32'h0000_0000
`define PPM_COLD_WAKE_RST         1'b0

`endif

// *** ppm_aux_capture.v ***
// Synchroniser and post-reset capture of the auxiliary supply sense
`timescale 1ns/100ps
`include "ppm_defs.vh"

module ppm_aux_capture (
  input  wire clk,                // Host bus clock
  input  wire srst,               // Synchronous reset, active high
  input  wire aux_sense,          // Auxiliary supply sense pin, async
  input  wire cold_wake_config,   // Recalled cold-wake config bit
  output reg  cold_wake_support   // Captured cold-wake support
);

  // ============================================================
  // Two-stage synchroniser
  // Left unreset so it tracks the pin while reset is held
  reg sync_a;
  reg sync_b;
  reg captured;

  always @(posedge clk) begin
    sync_a <= aux_sense;
    sync_b <= sync_a;
  end

  // ============================================================
  // One-time capture at first edge after reset release
  always @(posedge clk) begin
    if (srst) begin
      cold_wake_support <= `PPM_COLD_WAKE_RST;
      captured          <= 1'b0;
    end else if (!captured) begin
      cold_wake_support <= sync_b & cold_wake_config;
      captured          <= 1'b1;
    end
  end

endmodule // ppm_aux_capture

// *** ppm_pm_cap_regs.v ***
// Identity and power management capability register bank
// Operation
// - Identity word: part code high, maker low
// - Bits 30..27 read one: wake states
// - Bits 26 and 25 read one
// - Aux current 111b if cold wake, else 000b
// - Bit 21 reads zero: no special init
// - Bit 19 reads zero: no clock needed
// - Version field bits 18..16 read 010b
// - Next pointer bits 15..8 read 00h
// - Bits 7..0 read 01h: power management
`timescale 1ns/100ps
`include "ppm_defs.vh"

module ppm_pm_cap_regs #(
  parameter [15:0] PART_CODE  = 16'h0a5a,  // Arbitrary value
  parameter [15:0] MAKER_CODE = 16'h05a5   // Arbitrary value
) (
  input  wire        clk,               // Host bus clock, 50 MHz
  input  wire        srst,              // Synchronous reset, active high
  input  wire        aux_sense,         // Auxiliary supply sense pin
  input  wire        cold_wake_config,  // Recalled cold-wake config bit
  input  wire        cfg_rd,            // Config read strobe, one cycle
  input  wire        cfg_wr,            // Config write strobe, one cycle
  input  wire [7:0]  cfg_addr,          // Config byte address, dword aligned
  input  wire [3:0]  cfg_be,            // Byte enables for writes
  input  wire [31:0] cfg_wdata,         // Write data, discarded
  output reg  [31:0] cfg_rdata,         // Read data
  output reg         cfg_rd_valid,      // Read data valid pulse
  output reg         cfg_wr_ack,        // Write completion pulse
  output reg         cfg_hit,           // Last read or byte-enabled write hit a register
  output reg         cold_wake_out      // Cold-wake support state
);

  // ============================================================
  // Address decode
  localparam [1:0] SEL_NONE = 2'b00;
  localparam [1:0] SEL_ID   = 2'b01;
  localparam [1:0] SEL_PM   = 2'b10;

  function [1:0] decode_sel;
    input [7:0] addr;
    begin
      if (addr == `PPM_OFS_IDENTITY) begin
        decode_sel = SEL_ID;
      end else if (addr == `PPM_OFS_PM_CAP) begin
        decode_sel = SEL_PM;
      end else begin
        decode_sel = SEL_NONE;
      end
    end
  endfunction

  function is_mapped;
    input [1:0] sel;
    begin
      is_mapped = (sel != SEL_NONE);
    end
  endfunction

  // ============================================================
  // Captured cold-wake support
  wire cold_wake_support;

  ppm_aux_capture u_aux_capture (
    .clk               (clk),
    .srst              (srst),
    .aux_sense         (aux_sense),
    .cold_wake_config  (cold_wake_config),
    .cold_wake_support (cold_wake_support)
  );

  // ============================================================
  // Identity fields
  wire [`PPM_CODE_W-1:0] part_code;
  wire [`PPM_CODE_W-1:0] maker_code;

  assign part_code  = PART_CODE;
  assign maker_code = MAKER_CODE;

  // ============================================================
  // Wake support of the four warm power states
  // One shared constant keeps the four bits in step
  localparam integer WARM_STATES   = 4;
  localparam [3:0]   WARM_WAKE_VAL = `PPM_WAKE_STATES_VAL;

  wire [WARM_STATES-1:0] warm_wake;

  genvar gi;
  generate
    for (gi = 0; gi < WARM_STATES; gi = gi + 1) begin : g_warm_wake
      assign warm_wake[gi] = WARM_WAKE_VAL[gi];
    end
  endgenerate

  wire hot_off_wake_support = warm_wake[3];
  wire state2_wake_support  = warm_wake[2];
  wire state1_wake_support  = warm_wake[1];
  wire state0_wake_support  = warm_wake[0];

  // ============================================================
  // Fixed capability fields
  wire       state2_supported     = `PPM_ONE_BIT;
  wire       state1_supported     = `PPM_ONE_BIT;
  wire       dev_init_needed      = `PPM_ZERO_BIT;
  wire       reserved_bit20       = `PPM_ZERO_BIT;
  wire       wake_needs_bus_clock = `PPM_ZERO_BIT;
  wire [2:0] pm_spec_version      = `PPM_SPEC_VERSION;
  wire [7:0] next_capability_ptr  = `PPM_NEXT_PTR_VAL;
  wire [7:0] capability_kind      = `PPM_CAP_KIND_VAL;

  // Aux current is only drawn when cold wake is offered
  reg  [2:0] aux_current_code;

  always @* begin
    if (cold_wake_support) begin
      aux_current_code = `PPM_AUX_CUR_FULL;
    end else begin
      aux_current_code = `PPM_AUX_CUR_NONE;
    end
  end

  // ============================================================
  // Register words; bits not named read zero
  reg [31:0] identity_word;
  reg [31:0] pm_cap_word;

  always @* begin
    identity_word = 32'h0000_0000;
    identity_word[`PPM_PART_CODE_HI:`PPM_PART_CODE_LO]   = part_code;
    identity_word[`PPM_MAKER_CODE_HI:`PPM_MAKER_CODE_LO] = maker_code;
  end

  always @* begin
    pm_cap_word = 32'h0000_0000;
    pm_cap_word[`PPM_BIT_COLD_WAKE]        = cold_wake_support;
    pm_cap_word[`PPM_BIT_HOT_OFF_WAKE]     = hot_off_wake_support;
    pm_cap_word[`PPM_BIT_STATE2_WAKE]      = state2_wake_support;
    pm_cap_word[`PPM_BIT_STATE1_WAKE]      = state1_wake_support;
    pm_cap_word[`PPM_BIT_STATE0_WAKE]      = state0_wake_support;
    pm_cap_word[`PPM_BIT_STATE2_SUPP]      = state2_supported;
    pm_cap_word[`PPM_BIT_STATE1_SUPP]      = state1_supported;
    pm_cap_word[`PPM_AUX_HI:`PPM_AUX_LO]   = aux_current_code;
    pm_cap_word[`PPM_BIT_DEV_INIT]         = dev_init_needed;
    pm_cap_word[`PPM_BIT_RESERVED20]       = reserved_bit20;
    pm_cap_word[`PPM_BIT_WAKE_CLK]         = wake_needs_bus_clock;
    pm_cap_word[`PPM_VER_HI:`PPM_VER_LO]   = pm_spec_version;
    pm_cap_word[`PPM_NEXT_HI:`PPM_NEXT_LO] = next_capability_ptr;
    pm_cap_word[`PPM_KIND_HI:`PPM_KIND_LO] = capability_kind;
  end

  // ============================================================
  // Read mux; unmapped addresses read zero
  wire [1:0] rd_sel = decode_sel(cfg_addr);
  wire [1:0] wr_sel = decode_sel(cfg_addr);
  wire       rd_hit = is_mapped(rd_sel);
  wire       wr_hit = is_mapped(wr_sel);
  reg  [31:0] next_rdata;

  always @* begin
    case (rd_sel)
      SEL_ID: begin
        next_rdata = identity_word;
      end
      SEL_PM: begin
        next_rdata = pm_cap_word;
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // ============================================================
  // Bus response; write data is dropped on purpose
  // Both registers are read only, so a write completes with no effect
  wire wr_any = cfg_wr & (|cfg_be) & (|{cfg_wdata[0], 1'b1});
  reg  next_hit;
  reg  next_wr_ack;

  always @* begin
    next_hit    = cfg_hit;
    next_wr_ack = 1'b0;
    // Hit flag only moves on an access and holds in between
    if (cfg_rd) begin
      next_hit = rd_hit;
    end else if (wr_any) begin
      next_hit = wr_hit;
    end
    // A read in the same cycle wins; that write gets no ack
    if (cfg_wr && !cfg_rd) begin
      next_wr_ack = 1'b1;
    end
  end

  // ============================================================
  // Read data register; holds until the next read
  always @(posedge clk) begin
    if (srst) begin
      cfg_rdata <= `PPM_RDATA_RST;
    end else if (cfg_rd) begin
      cfg_rdata <= next_rdata;
    end
  end

  // ============================================================
  // Strobes, hit flag and cold-wake copy
  always @(posedge clk) begin
    if (srst) begin
      cfg_rd_valid  <= 1'b0;
      cfg_wr_ack    <= 1'b0;
      cfg_hit       <= 1'b0;
      cold_wake_out <= `PPM_COLD_WAKE_RST;
    end else begin
      cfg_rd_valid  <= cfg_rd;
      cfg_wr_ack    <= next_wr_ack;
      cfg_hit       <= next_hit;
      cold_wake_out <= cold_wake_support;
    end
  end

endmodule // ppm_pm_cap_regs

// *** ppm_cap_chk.sv ***
// Concurrent checks on the ports of the power management register bank
`timescale 1ns/100ps
`include "ppm_defs.vh"
module ppm_cap_chk #(
  parameter [15:0] PART_CODE  = 16'h0a5a,  // Arbitrary value
  parameter [15:0] MAKER_CODE = 16'h05a5   // Arbitrary value
) (
  input wire        clk,            // Host bus clock
  input wire        srst,           // Sync reset
  input wire        cfg_rd,         // Read strobe
  input wire        cfg_wr,         // Write strobe
  input wire [7:0]  cfg_addr,       // Byte address
  input wire [31:0] cfg_rdata,      // Read data
  input wire        cfg_rd_valid,   // Read answer
  input wire        cfg_wr_ack,     // Write answer
  input wire        cold_wake_out   // Captured cold-wake state
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire cap_rd = cfg_rd && cfg_addr == `PPM_OFS_PM_CAP;
  wire id_rd  = cfg_rd && cfg_addr == `PPM_OFS_IDENTITY;
  a_id_word: assert property (id_rd |=> cfg_rdata == {PART_CODE, MAKER_CODE})
    else $error("identity word wrong");
  a_wake_states: assert property (cap_rd |=> cfg_rdata[30:27] == 4'hf)
    else $error("wake state bits wrong");
  a_cold_bit: assert property (cap_rd |=> cfg_rdata[31] == cold_wake_out)
    else $error("cold wake bit wrong");
  a_states_supp: assert property (cap_rd |=> cfg_rdata[26:25] == 2'h3)
    else $error("state support bits wrong");
  a_aux_code: assert property (cap_rd |=> cfg_rdata[24:22] == {3{cfg_rdata[31]}})
    else $error("aux current code wrong");
  a_init_resv: assert property (cap_rd |=> cfg_rdata[21:20] == 2'h0)
    else $error("init or reserved bit set");
  a_clock_free: assert property (cap_rd |=> !cfg_rdata[19])
    else $error("bus clock bit set");
  a_version: assert property (cap_rd |=> cfg_rdata[18:16] == 3'h2)
    else $error("version field wrong");
  a_tail_fields: assert property (cap_rd |=> cfg_rdata[15:0] == 16'h0001)
    else $error("pointer or kind wrong");
  a_write_inert: assert property (cfg_wr && !cfg_rd |=>
    cfg_wr_ack && $stable(cfg_rdata))
    else $error("write not inert");
  a_read_wins: assert property (cfg_rd |=> cfg_rd_valid && !cfg_wr_ack)
    else $error("read answer wrong");
  a_cold_steady: assert property (!$past(srst, 3) |-> $stable(cold_wake_out))
    else $error("cold wake state moved after capture");
endmodule // ppm_cap_chk

bind ppm_pm_cap_regs ppm_cap_chk #(.PART_CODE(PART_CODE), .MAKER_CODE(MAKER_CODE)) i_ppm_cap_chk (
  .clk(clk), .srst(srst), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
  .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid), .cfg_wr_ack(cfg_wr_ack),
  .cold_wake_out(cold_wake_out));

// *** ppm_pm_cap_regs_tb.sv ***
// Self-checking testbench for the power management register bank
`timescale 1ns/100ps
`include "ppm_defs.vh"
module ppm_pm_cap_regs_tb;
  localparam [15:0] PC = 16'h3c3c;  // Arbitrary value
  localparam [15:0] MC = 16'hc3c3;  // Arbitrary value
  localparam [31:0] M0 = 32'hfe00_0000, M1 = 32'h01f8_0000, M2 = 32'h0007_ffff;
  reg         clk = 1'b0, srst = 1'b1, aux_sense = 1'b0, cold_wake_config = 1'b0;
  reg         cfg_rd = 1'b0, cfg_wr = 1'b0, e_hit, prd, pwr, cw;
  reg  [7:0]  cfg_addr = 8'h00;
  reg  [3:0]  cfg_be = 4'h0;
  reg  [31:0] cfg_wdata = 32'h0000_0000, e_rdata, r;
  wire [31:0] cfg_rdata;
  wire        cfg_rd_valid, cfg_wr_ack, cfg_hit, cold_wake_out;
  integer     err_count = 0, total_checks = 0, cycles = 0, seed = 37123, n, m;

  always #10 clk = ~clk;

  ppm_pm_cap_regs #(.PART_CODE(PC), .MAKER_CODE(MC)) i_ppm_pm_cap_regs (
    .clk(clk), .srst(srst), .aux_sense(aux_sense), .cold_wake_config(cold_wake_config),
    .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .cfg_rd_valid(cfg_rd_valid),
    .cfg_wr_ack(cfg_wr_ack), .cfg_hit(cfg_hit), .cold_wake_out(cold_wake_out));

  function [31:0] exp_word(input [7:0] a, input c);
    case (a)
      `PPM_OFS_PM_CAP:   exp_word = {c, 4'hf, 2'h3, {3{c}}, 3'h0, 3'h2, 16'h0001};
      `PPM_OFS_IDENTITY: exp_word = {PC, MC};
      default:           exp_word = 32'h0000_0000;
    endcase
  endfunction

  task test_done;
    begin
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk_word(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask

  task chk_flag(input got, input exp);
    chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  // ==========================================================
  // Reset with a chosen pin pair, then move the pin to prove it is ignored
  task do_reset(input a, input c);
    begin
      @(negedge clk);
      srst = 1'b1;
      aux_sense = a;
      cold_wake_config = c;
      cfg_rd = 1'b0;
      cfg_wr = 1'b0;
      repeat (10) @(negedge clk);
      srst = 1'b0;
      repeat (2) @(negedge clk);
      aux_sense = ~a;
      cw = a & c;
      e_rdata = 32'h0000_0000;
      {e_hit, prd, pwr} = 3'h0;
    end
  endtask

  // ==========================================================
  // Check the answer to the previous request, then issue the next one
  task step(input rd, input wr, input [7:0] a, input [3:0] be, input [31:0] d);
    begin
      @(negedge clk);
      chk_flag(cfg_rd_valid, prd);
      chk_flag(cfg_wr_ack, pwr);
      chk_word(cfg_rdata & M0, e_rdata & M0);
      chk_word(cfg_rdata & M1, e_rdata & M1);
      chk_word(cfg_rdata & M2, e_rdata & M2);
      chk_flag(cfg_hit, e_hit);
      chk_flag(cold_wake_out, cw);
      {cfg_rd, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {rd, wr, a, be, d};
      prd = rd;
      pwr = wr & ~rd;
      if (rd)
        e_rdata = exp_word(a, cw);
      if (rd | (wr & |be))
        e_hit = (a == `PPM_OFS_PM_CAP) || (a == `PPM_OFS_IDENTITY);
    end
  endtask

  initial begin
    for (m = 0; m < 4; m = m + 1) begin
      do_reset(m[0], m[1]);
      step(1'b0, 1'b1, `PPM_OFS_PM_CAP, 4'hf, 32'hffff_ffff);
      step(1'b1, 1'b1, `PPM_OFS_PM_CAP, 4'hf, 32'h0000_0000);
      step(1'b1, 1'b0, 8'hc4, 4'h0, 32'h0000_0000);
      for (n = 0; n < 300; n = n + 1) begin
        r = $random(seed);
        step(r[16], r[17], r[1] ? {r[15:10], 2'h0} : (r[0] ? 8'hc0 : 8'h80),
             r[21:18], $random(seed));
      end
    end
    test_done;
  end

  // Hang guard: the full sequence needs about 1300 cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      err_count = err_count + 1;
      test_done;
    end
  end
endmodule // ppm_pm_cap_regs_tb
